// [rtl/sff_pkg.sv]
`default_nettype none
package sff_pkg;
    // ------------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_MODE = 8'h00;
    localparam logic [7:0] ADDR_CTRL = 8'h04;
    localparam logic [7:0] ADDR_DIV = 8'h08;
    localparam logic [7:0] ADDR_TXDATA = 8'h0c;
    localparam logic [7:0] ADDR_RXDATA = 8'h10;
    localparam logic [7:0] ADDR_IRQ_ST = 8'h14;
    localparam logic [7:0] ADDR_IRQ_MSK = 8'h18;
    localparam logic [7:0] ADDR_STATUS = 8'h1c;

    // ------------------------------------------------------------------
    // serial_format_mode field positions
    // ------------------------------------------------------------------
    localparam int MODE_SYNC_BIT = 7;
    localparam int MODE_CHR_BIT = 6;
    localparam int MODE_PE_BIT = 5;
    localparam int MODE_ODD_BIT = 4;
    localparam int MODE_STOP_BIT = 3;
    localparam int MODE_MP_BIT = 2;
    localparam int MODE_CKS_HI = 1;
    localparam int MODE_CKS_LO = 0;

    // ------------------------------------------------------------------
    // control, status and interrupt field positions
    // ------------------------------------------------------------------
    localparam int CTRL_TX_EN = 0;
    localparam int CTRL_RX_EN = 1;
    localparam int CTRL_MPB = 2;
    localparam int STAT_TX_BUSY = 0;
    localparam int STAT_RX_BUSY = 1;
    localparam int IRQ_TX_DONE = 0;
    localparam int IRQ_RX_FULL = 1;
    localparam int IRQ_PAR_ERR = 2;
    localparam int IRQ_FRM_ERR = 3;

    // ------------------------------------------------------------------
    // reset values and bus answers
    // ------------------------------------------------------------------
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] CTRL_MASK = 8'h07;
    localparam logic [7:0] DIV_RST = 8'hff;
    localparam logic [3:0] IRQ_RST = 4'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// [rtl/sff_serial_format.sv]
`timescale 1ns/100ps
`default_nettype none
module sff_serial_format (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic rxd,
    output logic txd,
    output logic sck,
    output logic irq
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] mode, ctrl, div;
        logic [3:0] irq_st, irq_msk;
        logic [8:0] rx_data;
        logic rxd_m, rxd_s, rxd_d, tx_act;
        logic [11:0] tx_fr;
        logic [3:0] tx_left;
        logic [14:0] tx_cnt;
        logic txd, sck, rx_act;
        logic [9:0] rx_sh;
        logic [3:0] rx_idx;
        logic [14:0] rx_cnt;
        logic aw_got, w_got;
        logic [7:0] awaddr, wdata;
        logic wstb, awready, wready, bvalid;
        logic [1:0] bresp;
        logic arready, rvalid;
        logic [8:0] rdata;
        logic [1:0] rresp;
        logic irq;
    } sff_state_t;
    sff_state_t s_ff, nxt_s;
    logic [1:0] rst_sync_ff;
    logic rst_n;

    // builds the whole frame so the shifter only ever moves one way
    function automatic logic [11:0] sff_frame(input logic [7:0] d,
        input logic async_m, input logic [3:0] dl, input logic has_x,
        input logic xb);
        logic [11:0] f;
        int p;
        f = 12'hfff;
        f[0] = !async_m; // start bit low
        p = int'(async_m);
        for (int i = 0; i < 8; i++)
            if (i < int'(dl))
                f[p + i] = d[i]; // lsb leaves first
        if (has_x)
            f[p + int'(dl)] = xb;
        return f; // upper ones are the stop bits
    endfunction
    // ------------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------------
    // async assert, clocked release through two flops
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            rst_sync_ff <= 2'h0;
        else
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
    assign rst_n = rst_sync_ff[1];
    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb
    begin
        logic sync_m, mp_e, pe_e, has_x, odd, tx_go, xbit, rerr;
        logic [3:0] dl, need, ev, clr;
        logic [7:0] dmask, rxd8;
        logic [14:0] blen, half;
        logic [8:0] rdat;
        nxt_s = s_ff;
        ev = 4'h0;
        clr = 4'h0;
        tx_go = 1'b0;
        rdat = 9'h000;
        rerr = 1'b0;
        // effective format; the overrides are resolved here once
        sync_m = s_ff.mode[sff_pkg::MODE_SYNC_BIT];
        mp_e = s_ff.mode[sff_pkg::MODE_MP_BIT] && !sync_m;
        // parity dropped under mp and in synchronous mode
        pe_e = s_ff.mode[sff_pkg::MODE_PE_BIT] && !mp_e && !sync_m;
        has_x = mp_e || pe_e;
        odd = s_ff.mode[sff_pkg::MODE_ODD_BIT];
        // seven bits only in start-stop mode
        dl = (!sync_m && s_ff.mode[sff_pkg::MODE_CHR_BIT]) ? 4'h7 : 4'h8;
        dmask = (dl == 4'h7) ? 8'h7f : 8'hff;
        need = dl + {3'h0, has_x} + 4'h1;
        // prescale folded into the bit length
        blen = (15'(s_ff.div) + 15'h0001)
            << {s_ff.mode[sff_pkg::MODE_CKS_HI:sff_pkg::MODE_CKS_LO], 1'b0};
        half = blen >> 1;
        rxd8 = s_ff.rx_sh[7:0] & dmask;
        xbit = s_ff.rx_sh[dl];

        // pin synchroniser; the second stage is sampled, the third only marks the falling edge
        nxt_s.rxd_m = rxd;
        nxt_s.rxd_s = s_ff.rxd_m;
        nxt_s.rxd_d = s_ff.rxd_s;

        // write channel: address and data taken in either order
        if (s_axi_awvalid && s_ff.awready)
        begin
            nxt_s.aw_got = 1'b1;
            nxt_s.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_ff.wready)
        begin
            nxt_s.w_got = 1'b1;
            nxt_s.wdata = s_axi_wdata[7:0];
            nxt_s.wstb = s_axi_wstrb[0];
        end
        if (s_ff.bvalid && s_axi_bready)
            nxt_s.bvalid = 1'b0;
        if (s_ff.aw_got && s_ff.w_got && !s_ff.bvalid)
        begin
            nxt_s.aw_got = 1'b0;
            nxt_s.w_got = 1'b0;
            nxt_s.bvalid = 1'b1;
            nxt_s.bresp = sff_pkg::RESP_OKAY;
            case (s_ff.awaddr)
                sff_pkg::ADDR_MODE:
                    if (s_ff.wstb)
                        nxt_s.mode = s_ff.wdata;
                sff_pkg::ADDR_CTRL:
                    if (s_ff.wstb)
                        nxt_s.ctrl = s_ff.wdata & sff_pkg::CTRL_MASK;
                sff_pkg::ADDR_DIV:
                    if (s_ff.wstb)
                        nxt_s.div = s_ff.wdata;
                sff_pkg::ADDR_TXDATA:
                    tx_go = s_ff.wstb;
                sff_pkg::ADDR_IRQ_ST:
                    if (s_ff.wstb)
                        clr = s_ff.wdata[3:0];
                sff_pkg::ADDR_IRQ_MSK:
                    if (s_ff.wstb)
                        nxt_s.irq_msk = s_ff.wdata[3:0];
                sff_pkg::ADDR_RXDATA, sff_pkg::ADDR_STATUS: ;
                default:
                    nxt_s.bresp = sff_pkg::RESP_SLVERR;
            endcase
        end
        nxt_s.awready = !nxt_s.aw_got && !nxt_s.bvalid;
        nxt_s.wready = !nxt_s.w_got && !nxt_s.bvalid;

        // read channel: one outstanding read, answered the next cycle
        case (s_axi_araddr)
            sff_pkg::ADDR_MODE: rdat = {1'b0, s_ff.mode};
            sff_pkg::ADDR_CTRL: rdat = {1'b0, s_ff.ctrl};
            sff_pkg::ADDR_DIV: rdat = {1'b0, s_ff.div};
            sff_pkg::ADDR_TXDATA: rdat = 9'h000;
            sff_pkg::ADDR_RXDATA: rdat = s_ff.rx_data;
            sff_pkg::ADDR_IRQ_ST: rdat = {5'h00, s_ff.irq_st};
            sff_pkg::ADDR_IRQ_MSK: rdat = {5'h00, s_ff.irq_msk};
            sff_pkg::ADDR_STATUS: rdat = {7'h00, s_ff.rx_act, s_ff.tx_act};
            default: rerr = 1'b1;
        endcase
        if (s_ff.rvalid && s_axi_rready)
            nxt_s.rvalid = 1'b0;
        if (s_axi_arvalid && s_ff.arready)
        begin
            nxt_s.rvalid = 1'b1;
            nxt_s.rdata = rdat;
            nxt_s.rresp = rerr ? sff_pkg::RESP_SLVERR : sff_pkg::RESP_OKAY;
        end
        nxt_s.arready = !nxt_s.rvalid;

        // transmitter; a write while busy is dropped, software polls busy
        if (s_ff.tx_act)
        begin
            // >= so a divisor change mid-frame cannot strand the counter
            if (s_ff.tx_cnt >= blen - 15'h0001)
            begin
                nxt_s.tx_cnt = 15'h0000;
                nxt_s.tx_fr = {1'b1, s_ff.tx_fr[11:1]};
                nxt_s.tx_left = s_ff.tx_left - 4'h1;
                if (s_ff.tx_left == 4'h1)
                begin
                    nxt_s.tx_act = 1'b0;
                    ev[sff_pkg::IRQ_TX_DONE] = 1'b1;
                end
            end
            else
                nxt_s.tx_cnt = s_ff.tx_cnt + 15'h0001;
        end
        else if (tx_go && s_ff.ctrl[sff_pkg::CTRL_TX_EN])
        begin
            nxt_s.tx_act = 1'b1;
            nxt_s.tx_cnt = 15'h0000;
            nxt_s.rx_idx = sync_m ? 4'h0 : s_ff.rx_idx;
            // even parity xors to zero, odd flips it
            nxt_s.tx_fr = sff_frame(s_ff.wdata & dmask, !sync_m, dl, has_x,
                mp_e ? s_ff.ctrl[sff_pkg::CTRL_MPB]
                     : (^(s_ff.wdata & dmask)) ^ odd);
            // start, data, extra bit, one or two stops
            nxt_s.tx_left = (sync_m ? 4'h0 : 4'h1) + dl + {3'h0, has_x}
                + (sync_m ? 4'h0
                   : (s_ff.mode[sff_pkg::MODE_STOP_BIT] ? 4'h2 : 4'h1));
        end
        nxt_s.txd = nxt_s.tx_act ? nxt_s.tx_fr[0] : 1'b1;
        // serial clock low in the first half of each bit, idles high
        nxt_s.sck = (sync_m && nxt_s.tx_act) ? (nxt_s.tx_cnt >= half) : 1'b1;

        // receiver
        if (sync_m)
        begin
            nxt_s.rx_act = 1'b0;
            // sample on the rising serial clock, eight bits, no parity
            if (s_ff.ctrl[sff_pkg::CTRL_RX_EN] && s_ff.tx_act && !s_ff.sck
                && nxt_s.sck)
            begin
                nxt_s.rx_sh[s_ff.rx_idx] = s_ff.rxd_s;
                if (s_ff.rx_idx == 4'h7)
                begin
                    nxt_s.rx_idx = 4'h0;
                    nxt_s.rx_data = {1'b0, nxt_s.rx_sh[7:0]};
                    ev[sff_pkg::IRQ_RX_FULL] = 1'b1;
                end
                else
                    nxt_s.rx_idx = s_ff.rx_idx + 4'h1;
            end
        end
        else if (!s_ff.rx_act)
        begin
            // falling edge while idle opens a character
            if (s_ff.ctrl[sff_pkg::CTRL_RX_EN] && s_ff.rxd_d && !s_ff.rxd_s)
            begin
                nxt_s.rx_act = 1'b1;
                nxt_s.rx_cnt = half;
                nxt_s.rx_idx = 4'h0;
            end
        end
        else if (s_ff.rx_cnt != 15'h0000)
            nxt_s.rx_cnt = s_ff.rx_cnt - 15'h0001;
        else
        begin
            nxt_s.rx_cnt = blen - 15'h0001;
            nxt_s.rx_idx = s_ff.rx_idx + 4'h1;
            if (s_ff.rx_idx == 4'h0)
            begin
                // start bit gone high at mid-bit: treat as a glitch
                if (s_ff.rxd_s)
                    nxt_s.rx_act = 1'b0;
            end
            else if (s_ff.rx_idx < need)
                nxt_s.rx_sh[s_ff.rx_idx - 4'h1] = s_ff.rxd_s;
            else
            begin
                // only this first stop bit is checked
                nxt_s.rx_act = 1'b0;
                nxt_s.rx_data = {mp_e ? xbit : 1'b0, rxd8};
                ev[sff_pkg::IRQ_RX_FULL] = 1'b1;
                ev[sff_pkg::IRQ_FRM_ERR] = !s_ff.rxd_s;
                ev[sff_pkg::IRQ_PAR_ERR] = pe_e
                    && (((^rxd8) ^ xbit) != odd);
            end
        end

        // sticky events; a set in the clearing cycle wins
        nxt_s.irq_st = (s_ff.irq_st & ~clr) | ev;
        nxt_s.irq = |(nxt_s.irq_st & nxt_s.irq_msk);
    end
    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_ff <= '0;
            s_ff.mode <= sff_pkg::MODE_RST;
            s_ff.ctrl <= sff_pkg::CTRL_RST;
            s_ff.div <= sff_pkg::DIV_RST;
            s_ff.irq_msk <= sff_pkg::IRQ_RST;
            s_ff.rxd_m <= 1'b1;
            s_ff.rxd_s <= 1'b1;
            s_ff.rxd_d <= 1'b1;
            s_ff.txd <= 1'b1;
            s_ff.sck <= 1'b1;
            s_ff.tx_fr <= 12'hfff;
        end
        else
            s_ff <= nxt_s;
    end

    // outputs straight from the state register
    assign s_axi_awready = s_ff.awready;
    assign s_axi_wready = s_ff.wready;
    assign s_axi_bvalid = s_ff.bvalid;
    assign s_axi_bresp = s_ff.bresp;
    assign s_axi_arready = s_ff.arready;
    assign s_axi_rvalid = s_ff.rvalid;
    assign s_axi_rdata = {23'h000000, s_ff.rdata};
    assign s_axi_rresp = s_ff.rresp;
    assign txd = s_ff.txd;
    assign sck = s_ff.sck;
    assign irq = s_ff.irq;
endmodule
`default_nettype wire

// [tb/sff_checker.sv]
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------------
// port-level checks: bus handshake and serial line timing
// ------------------------------------------------------------------
// the line checks assume the bench keeps every bit time at 4 or more
module sff_checker (
    input wire logic clk,
    input wire logic rstn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic txd,
    input wire logic sck
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    // response waits, unchanged, for the master
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=>
            s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold)
        else $error("write response dropped early");
    property p_b_after;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            |-> ##2 s_axi_bvalid;
    endproperty
    a_b_after: assert property (p_b_after)
        else $error("write response late");
    property p_aw_block;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_aw_block: assert property (p_aw_block)
        else $error("write taken while response pending");
    property p_r_after;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_r_after: assert property (p_r_after)
        else $error("read data late");
    property p_ar_block;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_ar_block: assert property (p_ar_block)
        else $error("read taken while data pending");
    // reads above the map answer with an error and no data
    property p_slverr;
        s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h1c |=>
            s_axi_rresp == sff_pkg::RESP_SLVERR && s_axi_rdata == 32'h0;
    endproperty
    a_slverr: assert property (p_slverr)
        else $error("unmapped read not refused");
    property p_start;
        $fell(txd) |=> !txd [*3];
    endproperty
    a_start: assert property (p_start)
        else $error("first line bit too short");
    property p_sck_low;
        $fell(sck) |=> !sck;
    endproperty
    a_sck_low: assert property (p_sck_low)
        else $error("serial clock low phase too short");
endmodule
bind sff_serial_format sff_checker u_chk (
    .clk(clk), .rstn(rstn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .txd(txd), .sck(sck)
);
`default_nettype wire

// [tb/sff_far_end.sv]
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------------
// far-end serial device
// ------------------------------------------------------------------
module sff_far_end (
    input wire logic clk,
    input wire logic txd,
    input wire logic sck,
    input wire logic sync_clr,
    input wire logic [15:0] bit_cycles,
    output logic rxd,
    output logic [10:0] cap,
    output logic [7:0] sync_cap,
    output logic [3:0] sync_cnt
);
    // line idles high until a frame is sent
    initial rxd = 1'b1;
    // sample mid-bit from the falling start edge, start bit in cap[0]
    initial
    begin
        cap = '1;
        forever
        begin
            @(negedge txd);
            repeat (bit_cycles / 2) @(posedge clk);
            for (int i = 0; i < 11; i++)
            begin
                cap[i] = txd; // lsb first
                repeat (bit_cycles) @(posedge clk);
            end
        end
    end
    // clocked capture shifts in lsb first on each rising serial clock
    always @(posedge sck or posedge sync_clr)
    begin
        if (sync_clr)
        begin
            sync_cap <= 8'h00;
            sync_cnt <= 4'h0;
        end
        else
        begin
            sync_cap <= {txd, sync_cap[7:1]};
            sync_cnt <= sync_cnt + 4'h1;
        end
    end
    // no release at the end, so frames sent back to back have no gap
    task automatic send(input logic [10:0] b, input int n);
        for (int i = 0; i < n; i++)
        begin
            @(posedge clk);
            rxd <= b[i]; // lsb first
            repeat (bit_cycles - 1) @(posedge clk);
        end
    endtask
endmodule
`default_nettype wire

// [tb/serial_frame_format_config_test.sv]
`timescale 1ns/100ps
`default_nettype none
module serial_frame_format_config_test;
    // ------------------------------------------------------------------
    // signals and format table
    // ------------------------------------------------------------------
    localparam logic [1:0] OK_R = sff_pkg::RESP_OKAY;
    localparam logic [1:0] ERR_R = sff_pkg::RESP_SLVERR;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] strb = 4'hf;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic sync_clr = 1'b0;
    logic [15:0] bt = 16'h0004;
    logic awready, wready, bvalid, arready, rvalid, rxd, txd, sck, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, v;
    logic [10:0] cap;
    logic [7:0] sync_cap;
    logic [3:0] sync_cnt;
    int mismatches = 0;
    int cmp_count = 0;
    int len, base;
    // mode, data, expected line bits and frame length in bits
    logic [7:0] tm [6] = '{8'h00, 8'h30, 8'h20, 8'h48, 8'h08, 8'h34};
    logic [7:0] td [6] = '{8'ha5, 8'h5b, 8'h5b, 8'h80, 8'h00, 8'h00};
    logic [10:0] te [6] = '{{2'b11, 8'ha5, 1'b0}, {2'b10, 8'h5b, 1'b0},
        {2'b11, 8'h5b, 1'b0}, {3'b111, 7'h00, 1'b0},
        {2'b11, 8'h00, 1'b0}, {2'b10, 8'h00, 1'b0}};
    int tn [6] = '{10, 11, 11, 10, 11, 11};
    // 100 MHz clock
    always #5 clk = ~clk;
    sff_serial_format u_dut (
        .clk(clk), .rstn(rstn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .rxd(rxd), .txd(txd), .sck(sck), .irq(irq)
    );
    sff_far_end u_far (
        .clk(clk), .txd(txd), .sck(sck), .sync_clr(sync_clr),
        .bit_cycles(bt), .rxd(rxd), .cap(cap), .sync_cap(sync_cap),
        .sync_cnt(sync_cnt)
    );
    // ------------------------------------------------------------------
    // bus and check tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] er);
        logic ad, wd;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ad && wd))
        begin
            @(posedge clk);
            ad = ad || (awready === 1'b1);
            wd = wd || (wready === 1'b1);
            awvalid <= !ad;
            wvalid <= !wd;
        end
        do @(posedge clk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk(bresp, er);
    endtask
    task automatic rd(input logic [7:0] a, input logic [1:0] er);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        v = rdata;
        chk(rresp, er);
    endtask
    // len counts from the falling start edge to the done interrupt
    task automatic tx(input logic [7:0] d);
        wr(sff_pkg::ADDR_TXDATA, {24'h0, d}, OK_R);
        while (txd !== 1'b0) @(posedge clk);
        len = 0;
        while (irq !== 1'b1)
        begin
            @(posedge clk);
            len++;
        end
        wr(sff_pkg::ADDR_IRQ_ST, 32'h1, OK_R);
        @(posedge clk);
        chk(irq, 1'b0);
        repeat (2 * bt) @(posedge clk);
    endtask
    task automatic give_verdict();
        if (mismatches == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ------------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------------
    initial
    begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        rd(sff_pkg::ADDR_MODE, OK_R);
        chk(v, 32'h0);
        wr(sff_pkg::ADDR_MODE, 32'ha5, OK_R);
        strb <= 4'h0;
        wr(sff_pkg::ADDR_MODE, 32'h5a, OK_R);
        strb <= 4'hf;
        rd(sff_pkg::ADDR_MODE, OK_R);
        chk(v, 32'ha5);
        wr(8'h40, 32'h1, ERR_R);
        rd(8'h40, ERR_R);
        wr(sff_pkg::ADDR_DIV, 32'h3, OK_R);
        wr(sff_pkg::ADDR_IRQ_MSK, 32'h1, OK_R);
        wr(sff_pkg::ADDR_CTRL, 32'h3, OK_R);
        // frame formats; length differences show data, parity and stops
        for (int i = 0; i < 6; i++)
        begin
            wr(sff_pkg::ADDR_MODE, {24'h0, tm[i]}, OK_R);
            tx(td[i]);
            if (i == 0)
                base = len - 40;
            chk(cap, te[i]);
            chk(len, base + tn[i] * 4);
        end
        // every baud clock prescale
        for (int k = 0; k < 4; k++)
        begin
            bt = 16'h0004 << (2 * k);
            wr(sff_pkg::ADDR_MODE, k, OK_R);
            tx(8'h55);
            chk(cap, {2'b11, 8'h55, 1'b0});
            chk(len, base + 10 * bt);
        end
        bt = 16'h0004;
        // clocked mode ignores length, parity and multiprocessor bits
        wr(sff_pkg::ADDR_MODE, 32'he4, OK_R);
        sync_clr <= 1'b1;
        @(posedge clk);
        sync_clr <= 1'b0;
        tx(8'h96);
        chk(sync_cap, 8'h96);
        chk(sync_cnt, 4'h8);
        // idle line clocked in: full eight bits, no parity fault, no mp bit
        rd(sff_pkg::ADDR_IRQ_ST, OK_R);
        chk(v, 32'h2);
        rd(sff_pkg::ADDR_RXDATA, OK_R);
        chk(v, 32'hff);
        wr(sff_pkg::ADDR_IRQ_ST, 32'hf, OK_R);
        // masked event stays quiet until unmasked
        wr(sff_pkg::ADDR_MODE, 32'h0, OK_R);
        wr(sff_pkg::ADDR_IRQ_MSK, 32'h0, OK_R);
        wr(sff_pkg::ADDR_TXDATA, 32'h33, OK_R);
        repeat (60) @(posedge clk);
        chk(irq, 1'b0);
        rd(sff_pkg::ADDR_IRQ_ST, OK_R);
        chk(v, 32'h1);
        wr(sff_pkg::ADDR_IRQ_MSK, 32'hf, OK_R);
        @(posedge clk);
        chk(irq, 1'b1);
        wr(sff_pkg::ADDR_IRQ_ST, 32'hf, OK_R);
        // receive: one frame with good parity
        wr(sff_pkg::ADDR_MODE, 32'h20, OK_R);
        u_far.send({2'b10, 8'h3c, 1'b0}, 11);
        repeat (4) @(posedge clk);
        rd(sff_pkg::ADDR_IRQ_ST, OK_R);
        chk(v, 32'h2);
        rd(sff_pkg::ADDR_RXDATA, OK_R);
        chk(v, 32'h3c);
        wr(sff_pkg::ADDR_IRQ_ST, 32'hf, OK_R);
        // two stops selected, yet one-stop frames back to back still land
        wr(sff_pkg::ADDR_MODE, 32'h28, OK_R);
        u_far.send({2'b11, 8'h3d, 1'b0}, 11);
        u_far.send({2'b11, 8'hc3, 1'b0}, 11);
        repeat (4) @(posedge clk);
        rd(sff_pkg::ADDR_IRQ_ST, OK_R);
        chk(v, 32'h6);
        rd(sff_pkg::ADDR_RXDATA, OK_R);
        chk(v, 32'hc3);
        wr(sff_pkg::ADDR_IRQ_ST, 32'hf, OK_R);
        // low stop bit is a framing fault
        u_far.send({2'b00, 8'h11, 1'b0}, 11);
        u_far.send(11'h1, 1);
        rd(sff_pkg::ADDR_IRQ_ST, OK_R);
        chk(v, 32'ha);
        // multiprocessor bit lands in the receive word
        wr(sff_pkg::ADDR_MODE, 32'h04, OK_R);
        u_far.send({2'b11, 8'h42, 1'b0}, 11);
        repeat (4) @(posedge clk);
        rd(sff_pkg::ADDR_RXDATA, OK_R);
        chk(v, 32'h142);
        give_verdict();
    end
    // watchdog well beyond the longest expected run
    initial
    begin
        #800000;
        mismatches++;
        give_verdict();
    end
endmodule
`default_nettype wire
